// ==== src/spio_pkg.sv ====
package spio_pkg;
    // register byte offsets on the bus
    localparam logic [7:0] OFF_MAIN_SEL = 8'h00;
    localparam logic [7:0] OFF_OUT_SEL = 8'h04;
    localparam logic [7:0] OFF_FILTER = 8'h08;
    localparam logic [7:0] OFF_CH1_SET = 8'h0c;
    localparam logic [7:0] OFF_CH2_SET = 8'h10;
    localparam logic [7:0] OFF_CH1_CNT = 8'h14;
    localparam logic [7:0] OFF_CH2_CNT = 8'h18;
    localparam logic [7:0] OFF_FLAGS = 8'h1c;
    localparam logic [7:0] OFF_SCAN = 8'h20;
    localparam logic [7:0] OFF_STATUS = 8'h24;
    // flags register bit positions, channel 2 at +8
    localparam int FLAG_GATE = 0;
    localparam int FLAG_IRQ_EN = 1;
    localparam int FLAG_PRESET = 3;
    localparam int FLAG_CH2 = 8;
    // reset values
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [3:0] FILTER_DEFAULT_MS = 4'ha;
    // timing
    localparam int CLK_HZ = 20_000_000;
    localparam int MS_CYCLES = CLK_HZ / 1000;
    localparam int SAMPLE_UNIT_MS = 10;
    localparam int AC_ON_EXTRA_MS = 25;
    localparam int AC_OFF_EXTRA_MS = 30;
    localparam logic [6:0] SAMPLE_MIN = 7'h01;
    localparam logic [6:0] SAMPLE_MAX = 7'h64;
    // mode codes
    localparam logic [15:0] UPC_CH1 = 16'h1003;
    localparam logic [15:0] SPD_CH1 = 16'h1403;
    typedef enum logic [1:0] {
        SCAN_FIRST = 2'b00,
        SCAN_LOCKED = 2'b01
    } scan_e;
endpackage

// ==== src/special_io_counter.sv ====
// Overview of operation
// - function select words are sampled at first scan only; later writes ignored
// - filter on inputs 0..7, common delay 0..15 ms, default 10 ms
// - filter constant captured at first scan only
// - filter constant used only when F=1, E=0 and bits 9,8,5,4 are zero; otherwise the filter uses the default 10 ms
// - AC inputs: on delay 25 ms plus setting, off delay 30 ms plus setting
// - H1003 selects channel 1 up-counter; C enables ch1, D enables ch2
// - H1403 selects channel 1 speed-counter; bit A chooses speed counting
// - bits 2,1,0 select pulse-plus-direction; only bit 0 selects pwm
// - up-counter adds one per rising count edge while gate is on
// - count equal to latched set clears to zero and requests interrupt if enabled
// - reset input on forces count to zero
// - count only while gate on; gate falling clears count
// - set value latched at gate rising edge; compare uses latched copy
// - gate off: preset flag loads set register into count
// - counts are unsigned 16-bit values
// - channel 1 uses first registers and program 1, channel 2 second and 2
// - unused channel inputs stay ordinary inputs
// - speed-counter totals rising edges per period into hold register
// - speed-counter runs only with gate on; hold is zero when gate off
// - sampling period 1..100 in 10 ms units
`timescale 1ns/1ps
`default_nettype none
module special_io_counter
    import spio_pkg::*;
#(
    parameter int MS_COUNT = MS_CYCLES,
    parameter bit AC_INPUTS = 1'b0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] raw_inputs,
    output logic [7:0] filtered_inputs,
    output logic [1:0] irq_program_req,
    output logic [3:0] general_input_mask,
    output logic [2:0] output_mode
);
    localparam int FW = 17;
    logic [15:0] main_function_select, output_function_select, filter_constant_value;
    logic [15:0] next_main, next_out, next_filt;
    logic [15:0] set_reg [2];
    logic [15:0] next_set [2];
    logic [15:0] flags, next_flags;
    scan_e scan, next_scan;
    logic [15:0] mode_main, mode_out, next_mode_main, next_mode_out;
    logic [3:0] filt_ms, next_filt_ms;
    logic [31:0] next_prdata;
    logic [1:0] next_irq;
    logic [3:0] next_gmask;
    logic [2:0] next_omode;
    logic [15:0] count [2];
    logic [15:0] next_count [2];
    logic [15:0] latched [2];
    logic [15:0] next_latched [2];
    logic [15:0] hold [2];
    logic [15:0] next_hold [2];
    logic [FW+8:0] samp_cnt [2];
    logic [FW+8:0] next_samp [2];
    logic [7:0] sync1, sync2, filt_state, next_filt_state;
    logic [FW+4:0] fcnt [8];
    logic [FW+4:0] next_fcnt [8];
    logic [7:0] prev_in, gate_prev;
    logic up_mode, spd_mode, filt_en;
    logic [1:0] ch_en;

    wire wr = psel && penable && pwrite;
    // read data is fetched in the setup cycle so that it stands while pready is high
    wire rd = psel && !penable && !pwrite;

    // mode decode from the words frozen at first scan
    assign up_mode = mode_main[1:0] == 2'b11 && mode_main[11:2] == 10'h000;
    assign spd_mode = mode_main[1:0] == 2'b11 && mode_main[11:2] == 10'h100;
    assign ch_en = mode_main[13:12];
    assign filt_en = mode_main[15] && !mode_main[14] && mode_main[9:8] == 2'b00
        && mode_main[5:4] == 2'b00;
    // interrupt input mode decode, reported in the status word
    wire int_mode = mode_main[0] && !mode_main[1];
    wire [3:0] int_edges = int_mode ? {mode_main[7:6], mode_main[3:2]} : 4'h0;

    always_comb begin
        next_main = main_function_select;
        next_out = output_function_select;
        next_filt = filter_constant_value;
        next_set = set_reg;
        next_flags = flags;
        next_scan = scan;
        next_mode_main = mode_main;
        next_mode_out = mode_out;
        next_filt_ms = filt_ms;
        next_prdata = prdata;
        if (wr) begin
            case (paddr)
                OFF_MAIN_SEL: next_main = pwdata[15:0];
                OFF_OUT_SEL: next_out = pwdata[15:0];
                OFF_FILTER: next_filt = pwdata[15:0];
                OFF_CH1_SET: next_set[0] = pwdata[15:0];
                OFF_CH2_SET: next_set[1] = pwdata[15:0];
                OFF_FLAGS: next_flags = pwdata[15:0];
                OFF_SCAN: begin
                    // end of first scan: freeze modes and filter
                    if (scan == SCAN_FIRST && pwdata[0]) begin
                        next_scan = SCAN_LOCKED;
                        next_mode_main = main_function_select;
                        next_mode_out = output_function_select;
                        next_filt_ms = filter_constant_value[3:0];
                    end
                end
                default: ;
            endcase
        end
        if (rd) begin
            case (paddr)
                OFF_MAIN_SEL: next_prdata = {16'h0000, main_function_select};
                OFF_OUT_SEL: next_prdata = {16'h0000, output_function_select};
                OFF_FILTER: next_prdata = {16'h0000, filter_constant_value};
                OFF_CH1_SET: next_prdata = {16'h0000, set_reg[0]};
                OFF_CH2_SET: next_prdata = {16'h0000, set_reg[1]};
                OFF_CH1_CNT: next_prdata = {16'h0000, spd_mode ? hold[0] : count[0]};
                OFF_CH2_CNT: next_prdata = {16'h0000, spd_mode ? hold[1] : count[1]};
                OFF_FLAGS: next_prdata = {16'h0000, flags};
                OFF_SCAN: next_prdata = {31'h0, scan == SCAN_LOCKED};
                OFF_STATUS: next_prdata = {20'h0, int_edges, 1'b0, output_mode, 1'b0, filt_en, spd_mode, up_mode};
                default: next_prdata = 32'h0;
            endcase
        end
        // preset flags are one-shot requests
        for (int c = 0; c < 2; c++) begin
            if (flags[FLAG_PRESET + FLAG_CH2*c] && !(wr && paddr == OFF_FLAGS)) begin
                next_flags[FLAG_PRESET + FLAG_CH2*c] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            main_function_select <= RST_WORD;
            output_function_select <= RST_WORD;
            filter_constant_value <= RST_WORD;
            set_reg[0] <= RST_WORD;
            set_reg[1] <= RST_WORD;
            flags <= RST_WORD;
            scan <= SCAN_FIRST;
            mode_main <= RST_WORD;
            mode_out <= RST_WORD;
            filt_ms <= FILTER_DEFAULT_MS;
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            main_function_select <= next_main;
            output_function_select <= next_out;
            filter_constant_value <= next_filt;
            set_reg <= next_set;
            flags <= next_flags;
            scan <= next_scan;
            mode_main <= next_mode_main;
            mode_out <= next_mode_out;
            filt_ms <= next_filt_ms;
            prdata <= next_prdata;
            pready <= psel && !pready;
            pslverr <= 1'b0;
        end
    end

    // input synchroniser and filter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= 8'h00;
            sync2 <= 8'h00;
        end else begin
            sync1 <= raw_inputs;
            sync2 <= sync1;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_filt
            logic [FW+4:0] lim;
            always_comb begin
                // ac variants add a fixed extra delay per direction
                lim = (FW+5)'(filt_en ? filt_ms : FILTER_DEFAULT_MS) * (FW+5)'(MS_COUNT);
                if (AC_INPUTS) begin
                    lim = lim + (FW+5)'(filt_state[gi] ? AC_OFF_EXTRA_MS : AC_ON_EXTRA_MS)
                        * (FW+5)'(MS_COUNT);
                end
                next_fcnt[gi] = '0;
                next_filt_state[gi] = filt_state[gi];
                if (sync2[gi] != filt_state[gi]) begin
                    if (fcnt[gi] >= lim) begin
                        next_filt_state[gi] = sync2[gi];
                    end else begin
                        next_fcnt[gi] = fcnt[gi] + 1'b1;
                    end
                end
            end
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    fcnt[gi] <= '0;
                    filt_state[gi] <= 1'b0;
                end else begin
                    fcnt[gi] <= next_fcnt[gi];
                    filt_state[gi] <= next_filt_state[gi];
                end
            end
        end
    endgenerate

    // counter channels
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ch
            logic gate, rise, rst_in, gfall, grise, hit;
            logic [FW+8:0] period;
            always_comb begin
                gate = flags[FLAG_GATE + FLAG_CH2*gi];
                rise = filt_state[gi] && !prev_in[gi];
                rst_in = filt_state[gi+2] && up_mode;
                gfall = gate_prev[gi] && !gate;
                grise = !gate_prev[gi] && gate;
                period = (FW+9)'(set_reg[gi][6:0] < SAMPLE_MIN ? SAMPLE_MIN
                    : (set_reg[gi][6:0] > SAMPLE_MAX ? SAMPLE_MAX : set_reg[gi][6:0]))
                    * (FW+9)'(SAMPLE_UNIT_MS) * (FW+9)'(MS_COUNT);
                next_count[gi] = count[gi];
                next_latched[gi] = grise ? set_reg[gi] : latched[gi];
                next_hold[gi] = hold[gi];
                next_samp[gi] = samp_cnt[gi];
                hit = 1'b0;
                if (ch_en[gi] && up_mode) begin
                    if (rise && gate) begin
                        if (count[gi] + 16'h0001 == latched[gi]) begin
                            next_count[gi] = 16'h0000;
                            hit = 1'b1;
                        end else begin
                            next_count[gi] = count[gi] + 16'h0001;
                        end
                    end
                    if (!gate && flags[FLAG_PRESET + FLAG_CH2*gi]) begin
                        next_count[gi] = set_reg[gi];
                    end
                    if (gfall || rst_in) begin
                        next_count[gi] = 16'h0000;
                        hit = 1'b0;
                    end
                end else if (ch_en[gi] && spd_mode) begin
                    if (!gate) begin
                        next_hold[gi] = 16'h0000;
                        next_count[gi] = 16'h0000;
                        next_samp[gi] = '0;
                    end else if (samp_cnt[gi] + 1'b1 >= period) begin
                        next_hold[gi] = count[gi] + {15'h0, rise};
                        next_count[gi] = 16'h0000;
                        next_samp[gi] = '0;
                    end else begin
                        next_samp[gi] = samp_cnt[gi] + 1'b1;
                        if (rise) begin
                            next_count[gi] = count[gi] + 16'h0001;
                        end
                    end
                end
                next_irq[gi] = hit && flags[FLAG_IRQ_EN + FLAG_CH2*gi];
                // unused channel keeps its pins as plain inputs
                next_gmask[gi] = !(ch_en[gi] && (up_mode || spd_mode));
                next_gmask[gi+2] = !(ch_en[gi] && up_mode);
            end
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    count[gi] <= 16'h0000;
                    latched[gi] <= 16'h0000;
                    hold[gi] <= 16'h0000;
                    samp_cnt[gi] <= '0;
                    irq_program_req[gi] <= 1'b0;
                    general_input_mask[gi] <= 1'b1;
                    general_input_mask[gi+2] <= 1'b1;
                end else begin
                    count[gi] <= next_count[gi];
                    latched[gi] <= next_latched[gi];
                    hold[gi] <= next_hold[gi];
                    samp_cnt[gi] <= next_samp[gi];
                    irq_program_req[gi] <= next_irq[gi];
                    general_input_mask[gi] <= next_gmask[gi];
                    general_input_mask[gi+2] <= next_gmask[gi+2];
                end
            end
        end
    endgenerate

    // output mode: bit0 pwm, bit1 cw/ccw, bit2 pulse-plus-direction
    always_comb begin
        next_omode = 3'b000;
        if (mode_out[12:0] == 13'h0003) next_omode = 3'b010;
        if (mode_out[12:0] == 13'h0007) next_omode = 3'b100;
        if (mode_out[12:0] == 13'h0001) next_omode = 3'b001;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_in <= 8'h00;
            gate_prev <= 2'b00;
            filtered_inputs <= 8'h00;
            output_mode <= 3'b000;
        end else begin
            prev_in <= filt_state;
            gate_prev <= {flags[FLAG_GATE + FLAG_CH2], flags[FLAG_GATE]};
            filtered_inputs <= filt_state;
            output_mode <= next_omode;
        end
    end

    // channel checks watch channel 1, a_free_pins both; channel 2 runs the same generate body
    a_reset_wins: assert property (@(posedge clk) disable iff (!rst_n)
        up_mode && ch_en[0] && filt_state[2] |=> count[0] == 16'h0000)
        else $error("reset input did not clear count");
    a_hold_zero: assert property (@(posedge clk) disable iff (!rst_n)
        spd_mode && ch_en[0] && !flags[FLAG_GATE] |=> hold[0] == 16'h0000)
        else $error("hold not zero with gate off");
    a_modes_frozen: assert property (@(posedge clk) disable iff (!rst_n)
        scan == SCAN_LOCKED |=> $stable(mode_main) && $stable(filt_ms))
        else $error("mode changed after first scan");
    a_count_step: assert property (@(posedge clk) disable iff (!rst_n)
        up_mode && ch_en[0] && flags[FLAG_GATE] && gate_prev[0] && !filt_state[2]
        && !flags[FLAG_PRESET] && !g_ch[0].rise |=> $stable(count[0]))
        else $error("count moved without edge");
    a_gate_fall: assert property (@(posedge clk) disable iff (!rst_n)
        up_mode && ch_en[0] && gate_prev[0] && !flags[FLAG_GATE] |=> count[0] == 16'h0000)
        else $error("gate fall did not clear");
    a_irq_cause: assert property (@(posedge clk) disable iff (!rst_n)
        irq_program_req[0] |-> $past(flags[FLAG_IRQ_EN]) && count[0] == 16'h0000)
        else $error("interrupt without wrap");
    a_latch_rise: assert property (@(posedge clk) disable iff (!rst_n)
        g_ch[0].grise |=> latched[0] == $past(set_reg[0]))
        else $error("set value not latched");
    a_out_mode: assert property (@(posedge clk) disable iff (!rst_n)
        mode_out[12:0] == 13'h0007 && $stable(mode_out) |=> output_mode == 3'b100)
        else $error("pulse-plus-direction not selected");
    a_out_cw: assert property (@(posedge clk) disable iff (!rst_n)
        mode_out[12:0] == 13'h0003 && $stable(mode_out) |=> output_mode == 3'b010)
        else $error("cw/ccw output not selected");
    a_out_pwm: assert property (@(posedge clk) disable iff (!rst_n)
        mode_out[12:0] == 13'h0001 && $stable(mode_out) |=> output_mode == 3'b001)
        else $error("pwm output not selected");
    a_scan_stays: assert property (@(posedge clk) disable iff (!rst_n)
        scan == SCAN_LOCKED |=> scan == SCAN_LOCKED)
        else $error("first scan reopened");
    a_filter_wait: assert property (@(posedge clk) disable iff (!rst_n)
        sync2[0] != filt_state[0] && fcnt[0] < g_filt[0].lim |=> $stable(filt_state[0]))
        else $error("filter passed an edge early");
    a_preset_load: assert property (@(posedge clk) disable iff (!rst_n)
        up_mode && ch_en[0] && !flags[FLAG_GATE] && !gate_prev[0] && flags[FLAG_PRESET] && !filt_state[2]
        |=> count[0] == $past(set_reg[0]))
        else $error("preset did not load count");
    a_gate_off_hold: assert property (@(posedge clk) disable iff (!rst_n)
        up_mode && ch_en[0] && !flags[FLAG_GATE] && !gate_prev[0] && !flags[FLAG_PRESET]
        && !filt_state[2] |=> $stable(count[0]))
        else $error("count moved with gate off");
    a_wrap_clear: assert property (@(posedge clk) disable iff (!rst_n)
        up_mode && ch_en[0] && flags[FLAG_GATE] && g_ch[0].rise && count[0] + 16'h0001 == latched[0]
        |=> count[0] == 16'h0000)
        else $error("count did not wrap at set value");
    a_period_end: assert property (@(posedge clk) disable iff (!rst_n)
        spd_mode && ch_en[0] && flags[FLAG_GATE] && samp_cnt[0] + 1'b1 >= g_ch[0].period
        |=> count[0] == 16'h0000 && samp_cnt[0] == '0)
        else $error("sampling window did not restart");
    a_free_pins: assert property (@(posedge clk) disable iff (!rst_n)
        up_mode && ch_en == 2'b11 |=> general_input_mask == 4'h0)
        else $error("counter pins left free");
endmodule
`default_nettype wire

// ==== sim/pulse_source.sv ====
`timescale 1ns/1ps
`default_nettype none
module pulse_source (
    input wire logic clk,
    output logic [7:0] raw_inputs
);
    initial raw_inputs = 8'h00;
    // callers enter just after a rising edge, so every level lasts whole clocks
    task automatic pulses(input int idx, input int n, input int hi, input int lo);
        for (int i = 0; i < n; i++) begin
            raw_inputs[idx] <= 1'b1;
            repeat (hi) @(posedge clk);
            raw_inputs[idx] <= 1'b0;
            repeat (lo) @(posedge clk);
        end
    endtask
    task automatic level(input int idx, input logic v);
        raw_inputs[idx] <= v;
        @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
    import spio_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] raw_inputs;
    logic [7:0] filtered_inputs;
    logic [1:0] irq_program_req;
    logic [3:0] general_input_mask;
    logic [2:0] output_mode;
    int err_count = 0;
    int num_checks = 0;
    int irq1 = 0;
    int irq2 = 0;
    logic [31:0] rd;
    logic [15:0] mains [3] = '{16'h1003, 16'h2003, 16'h3003};
    logic [15:0] outs [3] = '{16'h0003, 16'h0007, 16'h0001};
    logic [2:0] modes [3] = '{3'b010, 3'b100, 3'b001};
    logic [3:0] masks [3] = '{4'b1010, 4'b0101, 4'b0000};
    always #25 clk = ~clk;
    // one millisecond shortened to 4 clocks: 10 ms default filter is 40 clocks
    special_io_counter #(.MS_COUNT(4), .AC_INPUTS(1'b0)) special_io_counter_inst (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .raw_inputs(raw_inputs), .filtered_inputs(filtered_inputs), .irq_program_req(irq_program_req),
        .general_input_mask(general_input_mask), .output_mode(output_mode));
    pulse_source pulse_source_inst (.clk(clk), .raw_inputs(raw_inputs));
    always @(posedge clk) begin
        if (irq_program_req[0] === 1'b1) irq1 <= irq1 + 1;
        if (irq_program_req[1] === 1'b1) irq2 <= irq2 + 1;
    end
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 20) begin
                err_count++;
                $display("ERROR bus wait timed out");
                end_of_test();
            end
            @(posedge clk);
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic expect_reg(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb_xfer(1'b0, a, 32'h0);
        check(name, rd, exp);
    endtask
    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
    endtask
    task automatic cfg(input logic [15:0] m, input logic [15:0] o, input logic [15:0] f);
        do_reset();
        apb_xfer(1'b1, OFF_MAIN_SEL, {16'h0, m});
        apb_xfer(1'b1, OFF_OUT_SEL, {16'h0, o});
        apb_xfer(1'b1, OFF_FILTER, {16'h0, f});
        apb_xfer(1'b1, OFF_SCAN, 32'h1);
        // the frozen mode reaches the registered outputs one edge after the lock
        @(posedge clk);
    endtask
    // both edges of bit 7 must emerge within the window around the delay
    task automatic filt_delay(input int lo, input int hi);
        int n;
        for (int v = 1; v >= 0; v--) begin
            n = 0;
            pulse_source_inst.level(7, v[0]);
            while (filtered_inputs[7] !== v[0] && n < 100) begin
                n++;
                @(posedge clk);
            end
            check("filter delay", {31'h0, n >= lo && n <= hi}, 32'h1);
        end
    endtask
    task automatic cnt(input int n);
        pulse_source_inst.pulses(0, n, 16, 16);
        repeat (4) @(posedge clk);
    endtask
    initial begin
        int s;
        int k;
        int v;
        void'($urandom(56));
        do_reset();
        check("idle mask", {28'h0, general_input_mask}, 32'hf);
        check("idle output mode", {29'h0, output_mode}, 32'h0);
        expect_reg("main select", OFF_MAIN_SEL, 32'h0);
        expect_reg("ch1 count", OFF_CH1_CNT, 32'h0);
        apb_xfer(1'b1, 8'h3c, 32'h1234);
        expect_reg("unmapped", 8'h3c, 32'h0);
        check("slave error", {31'h0, pslverr}, 32'h0);
        for (int i = 0; i < 3; i++) begin
            cfg(mains[i], outs[i], 16'h2);
            check("output mode", {29'h0, output_mode}, {29'h0, modes[i]});
            check("free pins", {28'h0, general_input_mask}, {28'h0, masks[i]});
            expect_reg("status", OFF_STATUS, {25'h0, modes[i], 4'b0001});
            filt_delay(36, 46);
        end
        cfg(16'h3045, 16'h0000, 16'h0);
        expect_reg("interrupt mode", OFF_STATUS, 32'h500);
        check("interrupt free pins", {28'h0, general_input_mask}, 32'hf);
        cfg(16'h9003, 16'h0003, 16'h2);
        expect_reg("status", OFF_STATUS, 32'h25);
        filt_delay(6, 14);
        apb_xfer(1'b1, OFF_MAIN_SEL, 32'h0);
        apb_xfer(1'b1, OFF_OUT_SEL, 32'h1);
        apb_xfer(1'b1, OFF_FILTER, 32'hf);
        check("output mode locked", {29'h0, output_mode}, 32'h2);
        expect_reg("status locked", OFF_STATUS, 32'h25);
        filt_delay(6, 14);
        s = 3 + $urandom % 6;
        k = 1 + $urandom % (s - 1);
        apb_xfer(1'b1, OFF_CH1_SET, 32'(s));
        apb_xfer(1'b1, OFF_FLAGS, 32'h3);
        cnt(k);
        expect_reg("count", OFF_CH1_CNT, 32'(k));
        cnt(s - k);
        expect_reg("count wrap", OFF_CH1_CNT, 32'h0);
        check("irq1", 32'(irq1), 32'h1);
        // set register changed under a running gate: compare keeps the latched value
        apb_xfer(1'b1, OFF_CH1_SET, 32'hffff);
        cnt(s);
        check("irq1 latched set", 32'(irq1), 32'h2);
        cnt(2);
        expect_reg("count", OFF_CH1_CNT, 32'h2);
        apb_xfer(1'b1, OFF_FLAGS, 32'h2);
        expect_reg("gate fall", OFF_CH1_CNT, 32'h0);
        cnt(1);
        expect_reg("gate off", OFF_CH1_CNT, 32'h0);
        v = 1 + $urandom % 200;
        apb_xfer(1'b1, OFF_CH1_SET, 32'(v));
        apb_xfer(1'b1, OFF_FLAGS, 32'ha);
        expect_reg("preset", OFF_CH1_CNT, 32'(v));
        apb_xfer(1'b1, OFF_CH1_SET, 32'(v + 2));
        apb_xfer(1'b1, OFF_FLAGS, 32'h3);
        cnt(2);
        check("irq1 after preset", 32'(irq1), 32'h3);
        cnt(1);
        pulse_source_inst.pulses(2, 1, 16, 16);
        expect_reg("reset input", OFF_CH1_CNT, 32'h0);
        pulse_source_inst.level(2, 1'b1);
        cnt(2);
        expect_reg("reset held", OFF_CH1_CNT, 32'h0);
        pulse_source_inst.level(2, 1'b0);
        apb_xfer(1'b1, OFF_FLAGS, 32'h1);
        cnt(v + 2);
        check("irq1 masked", 32'(irq1), 32'h3);
        check("irq2 silent", 32'(irq2), 32'h0);
        cfg(16'h9403, 16'h0007, 16'h0);
        expect_reg("speed status", OFF_STATUS, 32'h46);
        apb_xfer(1'b1, OFF_CH1_SET, 32'h5);
        apb_xfer(1'b1, OFF_FLAGS, 32'h1);
        // a 20-clock pulse period puts exactly ten edges into any 200-clock window
        fork
            pulse_source_inst.pulses(0, 60, 10, 10);
        join_none
        repeat (500) @(posedge clk);
        expect_reg("hold 50 ms", OFF_CH1_CNT, 32'ha);
        apb_xfer(1'b1, OFF_CH1_SET, 32'h0);
        repeat (200) @(posedge clk);
        expect_reg("hold clamped", OFF_CH1_CNT, 32'h2);
        repeat (400) @(posedge clk);
        apb_xfer(1'b1, OFF_FLAGS, 32'h0);
        expect_reg("hold gate off", OFF_CH1_CNT, 32'h0);
        end_of_test();
    end
endmodule
`default_nettype wire
